// *** src/ctm_consts.svh ***
/*
 * Constants of the clock timer: register addresses, bit positions,
 * reset values, exception vectors and divider sizes.
 * Assumes inclusion by bare name from the clock timer sources.
 */
`ifndef CTM_CONSTS_SVH
`define CTM_CONSTS_SVH

`define CTM_ADDR_W          16
`define CTM_DATA_W          8
`define CTM_ADDR_PRIO       16'hFF20
`define CTM_ADDR_ENABLE     16'hFF22
`define CTM_ADDR_FLAG       16'hFF24
`define CTM_ADDR_CTRL       16'hFF40
`define CTM_ADDR_COUNT      16'hFF41

`define CTM_BIT_RUN         0
`define CTM_BIT_CLEAR       1
`define CTM_BIT_FREQ_OUTPUT_PIN_EN     3
`define CTM_FSEL_LSB        4
`define CTM_FSEL_MSB        6
`define CTM_PRIO_MSB        1
`define CTM_TICK_MSB        3

`define CTM_TAP_32HZ        2
`define CTM_TAP_8HZ         4
`define CTM_TAP_2HZ         6
`define CTM_TAP_1HZ         7

`define CTM_IDX_1HZ         0
`define CTM_IDX_2HZ         1
`define CTM_IDX_8HZ         2
`define CTM_IDX_32HZ        3

`define CTM_CNT_RST         8'h00
`define CTM_CNT_ONE         8'h01
`define CTM_PRIO_RST        2'h0
`define CTM_TICK_RST        4'h0
`define CTM_DATA_ZERO       8'h00

`define CTM_VEC_W           24
`define CTM_VEC_32HZ        24'h00001C
`define CTM_VEC_8HZ         24'h00001E
`define CTM_VEC_2HZ         24'h000020
`define CTM_VEC_1HZ         24'h000022
`define CTM_VEC_NONE        24'h000000

`define CTM_TICK_DIV_BITS   7
`define CTM_FDIV_W          3

`endif

// *** src/ctm_pkg.sv ***
/*
 * Types shared by the clock timer modules.
 * Assumes ctm_consts.svh is compiled alongside.
 */
package ctm_pkg;

    typedef struct packed {
        logic       enable;
        logic [2:0] sel;
    } ctm_freq_output_pin_cfg_type;

    typedef enum logic {
        CTM_STOPPED,
        CTM_RUNNING
    } ctm_run_state_type;

endpackage : ctm_pkg

// *** src/ctm_tick_gen.sv ***
/*
 * 256 Hz tick generator: synchronises the low oscillator pin and
 * divides it, giving a one-cycle strobe on each falling edge of the tap.
 * Assumes the low oscillator is far slower than the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ctm_consts.svh"

module ctm_tick_gen #(
    parameter int DIV_BITS = `CTM_TICK_DIV_BITS
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    input  wire logic low_osc_clock_in,
    output logic      osc_level_out,
    output logic      osc_rise_out,
    output logic      tick_out
);

    logic                s1_q;
    logic                s2_q;
    logic                s3_q;
    logic                level_q;
    logic                rise_q;
    logic                tick_q;
    logic [DIV_BITS-1:0] div_q;

    wire                 agree     = (s2_q == s3_q);
    wire                 rise      = agree & s3_q & ~level_q;
    wire  [DIV_BITS-1:0] div_d     = rise ? div_q + 1'b1 : div_q;
    wire                 tap_falls = div_q[DIV_BITS-1] & ~div_d[DIV_BITS-1];

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            tick_q  <= 1'b0;
            div_q   <= '0;
        end else begin
            s1_q    <= low_osc_clock_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= agree ? s3_q : level_q;
            rise_q  <= rise;
            tick_q  <= tap_falls;
            div_q   <= div_d;
        end
    end

    assign osc_level_out = level_q;
    assign osc_rise_out  = rise_q;
    assign tick_out      = tick_q;

endmodule // ctm_tick_gen

`default_nettype wire

// *** src/ctm_freq_out.sv ***
/*
 * Frequency output: divides the low or high oscillator by 1, 2, 4 or 8
 * and gates it onto the output pin from a flip-flop.
 * Assumes the low oscillator arrives already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ctm_consts.svh"

module ctm_freq_out (
    input  wire logic                      sys_clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      low_level_in,
    input  wire logic                      low_rise_in,
    input  wire logic                      high_osc_clock_in,
    input  wire ctm_pkg::ctm_freq_output_pin_cfg_type cfg_in,
    output logic                           freq_output_pin_out
);

    logic                   s1_q;
    logic                   s2_q;
    logic                   s3_q;
    logic                   hi_level_q;
    logic                   pin_q;
    logic [`CTM_FDIV_W-1:0] lo_div_q;
    logic [`CTM_FDIV_W-1:0] hi_div_q;

    wire                    agree   = (s2_q == s3_q);
    wire                    hi_rise = agree & s3_q & ~hi_level_q;
    wire  [`CTM_FDIV_W:0]   lo_taps = {lo_div_q, low_level_in};
    wire  [`CTM_FDIV_W:0]   hi_taps = {hi_div_q, hi_level_q};
    wire  [1:0]             ratio   = cfg_in.sel[1:0];
    wire                    src     = cfg_in.sel[2] ? hi_taps[ratio] : lo_taps[ratio];

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q       <= 1'b0;
            s2_q       <= 1'b0;
            s3_q       <= 1'b0;
            hi_level_q <= 1'b0;
            pin_q      <= 1'b0;
            lo_div_q   <= '0;
            hi_div_q   <= '0;
        end else begin
            s1_q       <= high_osc_clock_in;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            hi_level_q <= agree ? s3_q : hi_level_q;
            lo_div_q   <= low_rise_in ? lo_div_q + 1'b1 : lo_div_q;
            hi_div_q   <= hi_rise ? hi_div_q + 1'b1 : hi_div_q;
            pin_q      <= cfg_in.enable & src;
        end
    end

    assign freq_output_pin_out = pin_q;

endmodule // ctm_freq_out

`default_nettype wire

// *** src/ctm_clock_timer.sv ***
/*
 * Clock timer top: 8-bit tick counter, run/stop and clear control,
 * tick interrupt flags, enables, priority and frequency output select.
 * Assumes a one-cycle strobe register port from the CPU core and the
 * CPU interrupt mask level on the same clock.
 */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_consts.svh"

module ctm_clock_timer #(
    parameter int TICK_DIV_BITS = `CTM_TICK_DIV_BITS
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic [`CTM_ADDR_W-1:0] addr_in,
    input  wire logic [`CTM_DATA_W-1:0] wr_data_in,
    input  wire logic                   wr_stb_in,
    input  wire logic                   rd_stb_in,
    output logic      [`CTM_DATA_W-1:0] rd_data_out,
    input  wire logic [1:0]             cpu_mask_in,
    input  wire logic                   low_osc_clock_in,
    input  wire logic                   high_osc_clock_in,
    output logic                        freq_output_pin_out,
    output logic                        irq_req_out,
    output logic      [1:0]             irq_level_out,
    output logic      [`CTM_VEC_W-1:0]  irq_vector_out
);

    // Falling edges of the four interrupt taps between two counter values
    function automatic logic [3:0] tap_falls(input logic [7:0] old_v,
                                             input logic [7:0] new_v);
        logic [3:0] f;
        f                = 4'h0;
        f[`CTM_IDX_1HZ]  = old_v[`CTM_TAP_1HZ] & ~new_v[`CTM_TAP_1HZ];
        f[`CTM_IDX_2HZ]  = old_v[`CTM_TAP_2HZ] & ~new_v[`CTM_TAP_2HZ];
        f[`CTM_IDX_8HZ]  = old_v[`CTM_TAP_8HZ] & ~new_v[`CTM_TAP_8HZ];
        f[`CTM_IDX_32HZ] = old_v[`CTM_TAP_32HZ] & ~new_v[`CTM_TAP_32HZ];
        return f;
    endfunction

    // Vector of the most urgent pending factor, fastest tap first
    function automatic logic [`CTM_VEC_W-1:0] pick_vector(input logic [3:0] p);
        logic [`CTM_VEC_W-1:0] v;
        v = `CTM_VEC_NONE;
        if (p[`CTM_IDX_32HZ]) begin
            v = `CTM_VEC_32HZ;
        end else if (p[`CTM_IDX_8HZ]) begin
            v = `CTM_VEC_8HZ;
        end else if (p[`CTM_IDX_2HZ]) begin
            v = `CTM_VEC_2HZ;
        end else if (p[`CTM_IDX_1HZ]) begin
            v = `CTM_VEC_1HZ;
        end
        return v;
    endfunction

    ctm_pkg::ctm_run_state_type run_state_q;
    ctm_pkg::ctm_run_state_type run_state_d;
    ctm_pkg::ctm_freq_output_pin_cfg_type  freq_output_pin_cfg_q;
    ctm_pkg::ctm_freq_output_pin_cfg_type  freq_output_pin_cfg_d;

    logic                   run_req_q;
    logic [7:0]             cnt_q;
    logic [`CTM_PRIO_MSB:0] prio_q;
    logic [`CTM_TICK_MSB:0] enable_q;
    logic [`CTM_TICK_MSB:0] flag_q;
    logic [`CTM_DATA_W-1:0] rd_data_q;
    logic                   irq_req_q;
    logic [1:0]             irq_level_q;
    logic [`CTM_VEC_W-1:0]  irq_vector_q;

    logic                   tick;
    logic                   osc_level;
    logic                   osc_rise;

    ctm_tick_gen #(
        .DIV_BITS (TICK_DIV_BITS)
    ) u_tick (
        .sys_clk_in       (sys_clk_in),
        .rst_n_in         (rst_n_in),
        .low_osc_clock_in (low_osc_clock_in),
        .osc_level_out    (osc_level),
        .osc_rise_out     (osc_rise),
        .tick_out         (tick)
    );

    ctm_freq_out u_freq_output_pin (
        .sys_clk_in          (sys_clk_in),
        .rst_n_in            (rst_n_in),
        .low_level_in        (osc_level),
        .low_rise_in         (osc_rise),
        .high_osc_clock_in   (high_osc_clock_in),
        .cfg_in              (freq_output_pin_cfg_q),
        .freq_output_pin_out (freq_output_pin_out)
    );

    // Address decode
    wire sel_prio   = (addr_in == `CTM_ADDR_PRIO);
    wire sel_enable = (addr_in == `CTM_ADDR_ENABLE);
    wire sel_flag   = (addr_in == `CTM_ADDR_FLAG);
    wire sel_ctrl   = (addr_in == `CTM_ADDR_CTRL);
    wire sel_count  = (addr_in == `CTM_ADDR_COUNT);

    wire wr_prio    = wr_stb_in & sel_prio;
    wire wr_enable  = wr_stb_in & sel_enable;
    wire wr_flag    = wr_stb_in & sel_flag;
    wire wr_ctrl    = wr_stb_in & sel_ctrl;

    // Counter
    wire       running  = (run_state_q == ctm_pkg::CTM_RUNNING);
    wire       cnt_inc  = tick & running;
    wire       cnt_clr  = wr_ctrl & wr_data_in[`CTM_BIT_CLEAR];
    wire [7:0] cnt_next = cnt_q + `CTM_CNT_ONE;
    wire [7:0] cnt_d    = cnt_clr ? `CTM_CNT_RST :
                          cnt_inc ? cnt_next : cnt_q;

    // Run request applies only on the tick
    assign run_state_d = !tick     ? run_state_q :
                         run_req_q ? ctm_pkg::CTM_RUNNING :
                                     ctm_pkg::CTM_STOPPED;
    wire run_req_d = wr_ctrl ? wr_data_in[`CTM_BIT_RUN] : run_req_q;
    wire run_read  = run_req_q | running;

    assign freq_output_pin_cfg_d = wr_ctrl ?
        ctm_pkg::ctm_freq_output_pin_cfg_type'({wr_data_in[`CTM_BIT_FREQ_OUTPUT_PIN_EN],
                                     wr_data_in[`CTM_FSEL_MSB:`CTM_FSEL_LSB]}) :
        freq_output_pin_cfg_q;

    // Flags: a set in the same cycle as a clear wins
    wire [3:0] fall_evt  = cnt_inc ? tap_falls(cnt_q, cnt_next) : 4'h0;
    wire [3:0] flag_clr  = wr_flag ? wr_data_in[`CTM_TICK_MSB:0] : 4'h0;
    wire [3:0] flag_d    = (flag_q & ~flag_clr) | fall_evt;

    wire [3:0] enable_d  = wr_enable ? wr_data_in[`CTM_TICK_MSB:0] : enable_q;
    wire [1:0] prio_d    = wr_prio ? wr_data_in[`CTM_PRIO_MSB:0] : prio_q;

    // Interrupt request toward the CPU core
    wire [3:0] pending   = flag_q & enable_q;
    wire       irq_req_d = (|pending) & (prio_q > cpu_mask_in);
    wire [`CTM_VEC_W-1:0] irq_vec_d = pick_vector(pending);

    // Read data: unused bits read zero
    wire [7:0] ctrl_rd   = {1'b0, freq_output_pin_cfg_q.sel, freq_output_pin_cfg_q.enable,
                            1'b0, 1'b0, run_read};
    wire [7:0] rd_mux    = !rd_stb_in ? `CTM_DATA_ZERO :
                           sel_prio   ? {6'h00, prio_q} :
                           sel_enable ? {4'h0, enable_q} :
                           sel_flag   ? {4'h0, flag_q} :
                           sel_ctrl   ? ctrl_rd :
                           sel_count  ? cnt_q :
                                        `CTM_DATA_ZERO;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q       <= `CTM_CNT_RST;
            run_req_q   <= 1'b0;
            run_state_q <= ctm_pkg::CTM_STOPPED;
            freq_output_pin_cfg_q  <= '0;
        end else begin
            cnt_q       <= cnt_d;
            run_req_q   <= run_req_d;
            run_state_q <= run_state_d;
            freq_output_pin_cfg_q  <= freq_output_pin_cfg_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_q   <= `CTM_TICK_RST;
            enable_q <= `CTM_TICK_RST;
            prio_q   <= `CTM_PRIO_RST;
        end else begin
            flag_q   <= flag_d;
            enable_q <= enable_d;
            prio_q   <= prio_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_q    <= `CTM_DATA_ZERO;
            irq_req_q    <= 1'b0;
            irq_level_q  <= `CTM_PRIO_RST;
            irq_vector_q <= `CTM_VEC_NONE;
        end else begin
            rd_data_q    <= rd_mux;
            irq_req_q    <= irq_req_d;
            irq_level_q  <= prio_q;
            irq_vector_q <= irq_vec_d;
        end
    end

    assign rd_data_out    = rd_data_q;
    assign irq_req_out    = irq_req_q;
    assign irq_level_out  = irq_level_q;
    assign irq_vector_out = irq_vector_q;

endmodule // ctm_clock_timer

`default_nettype wire

// *** testbench/ctm_clock_timer_assertions.sv ***
/* Checker of the clock timer top ports.
   Assumes one clock domain and a bind into every ctm_clock_timer. */
`timescale 1ns/1ps
`default_nettype none
`include "ctm_consts.svh"
module ctm_clock_timer_checker #(
    parameter int TICK_DIV_BITS = 7
) (
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0]  wr_data_in,
    input wire logic        wr_stb_in,
    input wire logic        rd_stb_in,
    input wire logic [7:0]  rd_data_out,
    input wire logic [1:0]  cpu_mask_in,
    input wire logic        irq_req_out,
    input wire logic [1:0]  irq_level_out,
    input wire logic [23:0] irq_vector_out
);
    wire logic rd_p = rd_stb_in && addr_in == `CTM_ADDR_PRIO;
    wire logic rd_e = rd_stb_in && addr_in == `CTM_ADDR_ENABLE;
    wire logic rd_f = rd_stb_in && addr_in == `CTM_ADDR_FLAG;
    wire logic rd_c = rd_stb_in && addr_in == `CTM_ADDR_CTRL;
    wire logic rd_n = rd_stb_in && addr_in == `CTM_ADDR_COUNT;
    wire logic wr_p = wr_stb_in && addr_in == `CTM_ADDR_PRIO;
    wire logic wr_e = wr_stb_in && addr_in == `CTM_ADDR_ENABLE;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    ctrl_read_zero_a: assert property (rd_c |=> (rd_data_out & 8'h86) == 8'h00)
        else $error("control reserved bits not zero");
    prio_readback_a: assert property (wr_p ##1 !wr_stb_in ##1 rd_p
        |=> rd_data_out == ($past(wr_data_in, 3) & 8'h03))
        else $error("priority readback wrong");
    enable_readback_a: assert property (wr_e ##1 !wr_stb_in ##1 rd_e
        |=> rd_data_out == ($past(wr_data_in, 3) & 8'h0F))
        else $error("enable readback wrong");
    flag_upper_a: assert property (rd_f |=> rd_data_out[7:4] == 4'h0)
        else $error("flag upper bits not zero");
    count_step_a: assert property (rd_n ##1 rd_n
        |=> 8'(rd_data_out - $past(rd_data_out)) <= 8'h01)
        else $error("count stepped by more than one");
    irq_mask_a: assert property (irq_req_out |-> irq_level_out > $past(cpu_mask_in))
        else $error("request at or below mask");
    level_zero_a: assert property (irq_level_out == 2'h0 |-> !irq_req_out)
        else $error("request at level zero");
    vector_valid_a: assert property (irq_req_out |-> irq_vector_out inside
        {`CTM_VEC_32HZ, `CTM_VEC_8HZ, `CTM_VEC_2HZ, `CTM_VEC_1HZ})
        else $error("bad vector with request");

    cover property (irq_req_out && irq_vector_out == `CTM_VEC_32HZ);
    cover property (rd_n ##1 rd_n);
    cover property (wr_p ##1 !wr_stb_in ##1 rd_p);
endmodule // ctm_clock_timer_checker

bind ctm_clock_timer ctm_clock_timer_checker #(.TICK_DIV_BITS(TICK_DIV_BITS)) chk_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
    .rd_data_out(rd_data_out), .cpu_mask_in(cpu_mask_in), .irq_req_out(irq_req_out),
    .irq_level_out(irq_level_out), .irq_vector_out(irq_vector_out));
`default_nettype wire

// *** testbench/ctm_osc_model.sv ***
/* Free-running low and high oscillator sources.
   Assumes both run unrelated to the system clock. */
`timescale 1ns/1ps
`default_nettype none
module ctm_osc_model #(
    parameter int LOW_HALF_NS  = 200,
    parameter int HIGH_HALF_NS = 37
) (
    output logic low_osc_out,
    output logic high_osc_out
);
    initial low_osc_out = 1'b0;
    initial high_osc_out = 1'b0;
    always #(LOW_HALF_NS) low_osc_out = ~low_osc_out;
    always #(HIGH_HALF_NS) high_osc_out = ~high_osc_out;
endmodule // ctm_osc_model
`default_nettype wire

// *** testbench/ctm_clock_timer_tb_top.sv ***
/* Self-checking bench of the clock timer over its register port.
   Assumes a short tick divider and the oscillator model. */
`timescale 1ns/1ps
`default_nettype none
`include "ctm_consts.svh"
module ctm_clock_timer_tb_top;
    localparam logic [15:0] A_PRI = `CTM_ADDR_PRIO;
    localparam logic [15:0] A_EN  = `CTM_ADDR_ENABLE;
    localparam logic [15:0] A_FLG = `CTM_ADDR_FLAG;
    localparam logic [15:0] A_CTL = `CTM_ADDR_CTRL;
    localparam logic [15:0] A_CNT = `CTM_ADDR_COUNT;
    logic        sys_clk_in  = 1'b0;
    logic        rst_n_in    = 1'b0;
    logic [15:0] addr_in     = 16'h0000;
    logic [7:0]  wr_data_in  = 8'h00;
    logic        wr_stb_in   = 1'b0;
    logic        rd_stb_in   = 1'b0;
    logic [1:0]  cpu_mask_in = 2'h0;
    wire logic        low_osc, high_osc, freq_output_pin, irq_req;
    wire logic [7:0]  rd_data;
    wire logic [1:0]  irq_level;
    wire logic [23:0] irq_vec;
    int          miscompares = 0;
    int          checks_done = 0;
    logic [7:0]  c;
    logic [7:0]  d;
    logic [23:0] vec [4] = '{`CTM_VEC_1HZ, `CTM_VEC_2HZ, `CTM_VEC_8HZ, `CTM_VEC_32HZ};

    always #25 sys_clk_in = ~sys_clk_in;

    ctm_osc_model osc_u (.low_osc_out(low_osc), .high_osc_out(high_osc));
    ctm_clock_timer #(.TICK_DIV_BITS(1)) dut_u (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
        .rd_data_out(rd_data), .cpu_mask_in(cpu_mask_in), .low_osc_clock_in(low_osc),
        .high_osc_clock_in(high_osc), .freq_output_pin_out(freq_output_pin),
        .irq_req_out(irq_req), .irq_level_out(irq_level), .irq_vector_out(irq_vec));

    task automatic tally_and_finish();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        addr_in <= a;
        wr_data_in <= v;
        wr_stb_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_stb_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        addr_in <= a;
        rd_stb_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_stb_in <= 1'b0;
        #1 v = rd_data;
        @(posedge sys_clk_in);
    endtask
    task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        cmp(v, e);
    endtask
    // Two count reads back to back
    task automatic wait_cnt(input logic [7:0] prev, output logic [7:0] b);
        logic [7:0] a;
        for (int i = 0; i < 40; i++) begin
            addr_in <= A_CNT;
            rd_stb_in <= 1'b1;
            @(posedge sys_clk_in);
            #1 a = rd_data;
            @(posedge sys_clk_in);
            rd_stb_in <= 1'b0;
            #1 b = rd_data;
            @(posedge sys_clk_in);
            if (b !== prev) return;
        end
        cmp(b, 8'(prev + 8'h01));
        tally_and_finish();
    endtask
    task automatic wait_stop();
        logic [7:0] v;
        for (int i = 0; i < 40; i++) begin
            rd(A_CTL, v);
            if (v[0] === 1'b0) return;
        end
        cmp(v, 8'h00);
        tally_and_finish();
    endtask
    task automatic irq_is(input logic r, input logic [23:0] v);
        repeat (3) @(posedge sys_clk_in);
        #1 cmp(irq_req, r);
        if (r) cmp(irq_vec, v);
        @(posedge sys_clk_in);
    endtask

    task automatic t_reset();
        logic [15:0] am [5] = '{A_PRI, A_EN, A_FLG, A_CTL, A_CNT};
        for (int i = 0; i < 5; i++) chk_rd(am[i], 8'h00);
    endtask
    task automatic t_regs();
        wr(A_PRI, 8'hFF);
        chk_rd(A_PRI, 8'h03);
        wr(A_EN, 8'hFF);
        chk_rd(A_EN, 8'h0F);
        wr(A_CNT, 8'h5A);
        chk_rd(A_CNT, 8'h00);
        wr(A_CTL, 8'hFA);
        chk_rd(A_CTL, 8'h78);
        chk_rd(16'hFF21, 8'h00);
        wr(A_PRI, 8'h00);
        wr(A_EN, 8'h00);
        wr(A_CTL, 8'h00);
    endtask
    // Pin must toggle when enabled, for a low and a high source
    task automatic t_freq_output_pin();
        logic [7:0] codes [2] = '{8'h08, 8'hC8};
        int hi;
        int lo;
        for (int k = 0; k < 2; k++) begin
            hi = 0;
            lo = 0;
            wr(A_CTL, codes[k]);
            repeat (40) begin
                @(posedge sys_clk_in);
                #1 if (freq_output_pin === 1'b1) hi++; else lo++;
            end
            cmp(32'(hi > 0 && lo > 0), 32'h1);
        end
        @(posedge sys_clk_in);
        wr(A_CTL, 8'h00);
        hi = 0;
        repeat (20) begin
            @(posedge sys_clk_in);
            #1 if (freq_output_pin !== 1'b0) hi++;
        end
        cmp(hi, 0);
        @(posedge sys_clk_in);
    endtask
    task automatic t_run();
        wr(A_CTL, 8'h01);
        chk_rd(A_CTL, 8'h01);
        wait_cnt(8'h00, c);
        cmp(c, 8'h01);
        wait_cnt(c, c);
        wr(A_CTL, 8'h00);
        chk_rd(A_CTL, 8'h01);
        wait_stop();
        chk_rd(A_CNT, 8'(c + 8'h01));
        repeat (40) @(posedge sys_clk_in);
        chk_rd(A_CNT, 8'(c + 8'h01));
    endtask
    task automatic t_clear();
        wr(A_CTL, 8'h02);
        chk_rd(A_CNT, 8'h00);
        chk_rd(A_CTL, 8'h00);
        wr(A_CTL, 8'h01);
        wait_cnt(8'h00, c);
        wr(A_CTL, 8'h03);
        chk_rd(A_CNT, 8'h00);
        wait_cnt(8'h00, c);
        cmp(c, 8'h01);
    endtask
    task automatic t_irq();
        wr(A_FLG, 8'h0F);
        d = 8'h00;
        for (int i = 0; i < 3000 && d !== 8'h0F; i++) rd(A_FLG, d);
        cmp(d, 8'h0F);
        if (d !== 8'h0F) tally_and_finish();
        #1 cmp(irq_req, 1'b0);
        @(posedge sys_clk_in);
        // Software stops the timer before the flag clear checks
        wr(A_CTL, 8'h00);
        wait_stop();
        wr(A_FLG, 8'h00);
        chk_rd(A_FLG, 8'h0F);
        wr(A_EN, 8'h01);
        wr(A_PRI, 8'h02);
        cpu_mask_in <= 2'h1;
        irq_is(1'b1, `CTM_VEC_1HZ);
        #1 cmp(irq_level, 2'h2);
        @(posedge sys_clk_in);
        cpu_mask_in <= 2'h2;
        irq_is(1'b0, 24'h000000);
        wr(A_PRI, 8'h00);
        cpu_mask_in <= 2'h0;
        irq_is(1'b0, 24'h000000);
        wr(A_PRI, 8'h01);
        irq_is(1'b1, `CTM_VEC_1HZ);
        wr(A_EN, 8'h0F);
        irq_is(1'b1, `CTM_VEC_32HZ);
        for (int i = 3; i > 0; i--) begin
            wr(A_FLG, 8'(8'h01 << i));
            irq_is(1'b1, vec[i - 1]);
        end
        wr(A_FLG, 8'h01);
        irq_is(1'b0, 24'h000000);
        chk_rd(A_FLG, 8'h00);
    endtask

    initial begin
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        t_reset();
        t_regs();
        t_freq_output_pin();
        t_run();
        t_clear();
        t_irq();
        tally_and_finish();
    end
endmodule // ctm_clock_timer_tb_top
`default_nettype wire
